/* core/pgn_pkg.sv */
// Package of constants and types for the programmable pulse generator
package pgn_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 8;
    localparam int WIDTH_W = 9;
    localparam int DBNC_W  = 5;
    localparam int APPR_W  = 13;
    localparam int IVAL_W  = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_MAIN    = 8'hA8;
    localparam logic [7:0] OFS_IRQ_SECOND  = 8'hA9;
    localparam logic [7:0] OFS_CTRL_PRI    = 8'hB1;
    localparam logic [7:0] OFS_CTRL_SEC    = 8'hB2;
    localparam logic [7:0] OFS_RELOAD_LOW  = 8'hB3;
    localparam logic [7:0] OFS_SYNC_COUNT  = 8'hB4;
    localparam logic [7:0] OFS_TIMER_LOW   = 8'hB6;
    localparam logic [7:0] OFS_TIMER_HIGH  = 8'hB7;
    localparam logic [7:0] OFS_PRIO_LOW    = 8'hBA;
    localparam logic [7:0] OFS_PRIO_HIGH   = 8'hBB;
    localparam logic [7:0] OFS_DEBOUNCE    = 8'hC1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_OUT_EN       = 7;
    localparam int BIT_RELOAD_STYLE = 6;
    localparam int BIT_MODE         = 4;
    localparam int BIT_PRESCALE     = 3;
    localparam int BIT_CNT_EN       = 2;
    localparam int BIT_CNT_CLR      = 1;
    localparam int BIT_EDGE         = 0;
    localparam int POS_RATE         = 6;
    localparam int POS_WIDTH_DECREMENT_MODE         = 4;
    localparam int POS_STEP         = 1;
    localparam int BIT_RELOAD_MSB   = 0;
    localparam int BIT_GLOBAL_IRQ   = 7;
    localparam int BIT_PULSE_IRQ    = 5;

    // ------------------------------------------------------------
    // Reset values, codes and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic        MODE_SYNC      = 1'b1;
    localparam logic        DEC_CONST_LSB  = 1'b0;
    localparam logic [APPR_W-1:0] APPR_BASE = 13'h0200;
    localparam logic [1:0]  DIV2_LAST      = 2'h1;
    localparam logic [1:0]  DIV4_LAST      = 2'h3;
    localparam logic [3:0]  VAR_SHIFT_MAX  = 4'h6;
    localparam logic [3:0]  VAR_SHIFT_MIN  = 4'h3;

    typedef enum logic {
        PGN_IDLE,
        PGN_PULSE
    } pgn_state_t;

endpackage : pgn_pkg

/* core/pgn_clkdiv.sv */
// Pulse clock enable divider, system clock by 2 or by 4
`timescale 1ns/1ns
module pgn_clkdiv (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      tick
);

    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } pgn_div_t;

    pgn_div_t s_q;
    pgn_div_t s_d;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Count to the last phase, then emit one enable pulse
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= (slow ? pgn_pkg::DIV4_LAST : pgn_pkg::DIV2_LAST)) begin
            s_d.cnt  = 2'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = 2'(s_q.cnt + 2'h1);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : pgn_clkdiv

/* core/pgn_debounce.sv */
// Debounce filter for the comparator one trigger input
`timescale 1ns/1ns
module pgn_debounce (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       tick,
    input  wire logic [pgn_pkg::DBNC_W-1:0] len,
    input  wire logic                       din,
    output logic                            dout
);

    typedef struct packed {
        logic [pgn_pkg::DBNC_W-1:0] cnt;
        logic                       out;
    } pgn_dbn_t;

    pgn_dbn_t s_q;
    pgn_dbn_t s_d;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    // Accept a new level after it held len pulse clocks
    always_comb begin
        s_d = s_q;
        if (len == '0) begin
            s_d.out = din;
            s_d.cnt = '0;
        end else if (din == s_q.out) begin
            s_d.cnt = '0;
        end else if (tick) begin
            if (5'(s_q.cnt + 5'h01) >= len) begin
                s_d.out = din;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = 5'(s_q.cnt + 5'h01);
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.out;

endmodule : pgn_debounce

/* core/pgn_top.sv */
// Programmable pulse generator core with register port
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns

module pgn_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic        comparator_one_in,
    input  wire logic        comparator_two_in,
    output logic [7:0]       rd_data,
    output logic             pulse_out,
    output logic             irq_req,
    output logic             irq_prio_low,
    output logic             irq_prio_high
);

    typedef struct packed {
        logic [1:0]                  c1_sync;
        logic [1:0]                  c2_sync;
        logic                        c1_prev;
        logic                        c2_prev;
        logic                        out_en;
        logic                        reload_style;
        logic                        mode;
        logic                        prescale;
        logic                        cnt_en;
        logic                        cnt_clr;
        logic                        edge_sel;
        logic [1:0]                  rate;
        logic [1:0]                  width_decrement_mode;
        logic [2:0]                  step;
        logic [pgn_pkg::WIDTH_W-1:0] reload;
        logic [pgn_pkg::WIDTH_W-1:0] work;
        logic [pgn_pkg::WIDTH_W-1:0] timer;
        logic [7:0]                  sync_count;
        logic [pgn_pkg::APPR_W-1:0]  appr_cnt;
        logic [pgn_pkg::IVAL_W-1:0]  interval;
        logic                        global_irq;
        logic                        pulse_irq_en;
        logic                        prio_low;
        logic                        prio_high;
        logic [pgn_pkg::DBNC_W-1:0]  debounce;
        pgn_pkg::pgn_state_t         state;
        logic                        pulse;
        logic                        irq;
        logic [7:0]                  rd_data;
    } pgn_state_s_t;

    pgn_state_s_t s_q;
    pgn_state_s_t s_d;

    logic tick;
    logic c1_clean;

    // ------------------------------------------------------------
    // Pulse clock and input filter
    // ------------------------------------------------------------
    // Pulse clock enable
    pgn_clkdiv u_div (
        .clk  (clk),
        .rst  (rst),
        .slow (s_q.prescale),
        .tick (tick)
    );

    // Comparator one debounce after the synchroniser
    pgn_debounce u_dbn (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .len  (s_q.debounce),
        .din  (s_q.c1_sync[1]),
        .dout (c1_clean)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic                        sync_mode;
        logic                        c1_rise;
        logic                        c1_fall;
        logic                        trig_ev;
        logic                        c2_ev;
        logic                        wr_pri;
        logic                        wr_sec;
        logic                        wr_low;
        logic                        start;
        logic                        done;
        logic [9:0]                  dec_amt;
        logic [3:0]                  shift;
        logic [pgn_pkg::IVAL_W-1:0]  scaled;
        logic [pgn_pkg::WIDTH_W-1:0] tnext;
        logic [pgn_pkg::APPR_W-1:0]  appr_last;

        s_d       = s_q;
        sync_mode = (s_q.mode == pgn_pkg::MODE_SYNC);
        c1_rise   = c1_clean & ~s_q.c1_prev;
        c1_fall   = ~c1_clean & s_q.c1_prev;
        trig_ev   = sync_mode & (s_q.edge_sel ? c1_rise : c1_fall);
        c2_ev     = sync_mode & s_q.out_en & s_q.c2_sync[1]
                    & ~s_q.c2_prev;
        wr_pri    = wr_en & (addr == pgn_pkg::OFS_CTRL_PRI);
        wr_sec    = wr_en & (addr == pgn_pkg::OFS_CTRL_SEC);
        wr_low    = wr_en & (addr == pgn_pkg::OFS_RELOAD_LOW);
        start     = 1'b0;
        done      = 1'b0;
        tnext     = 9'(s_q.timer + 9'h001);
        appr_last = 13'((pgn_pkg::APPR_BASE << s_q.rate) - 13'h0001);
        shift     = s_q.step[2] ? pgn_pkg::VAR_SHIFT_MIN
                    : 4'(pgn_pkg::VAR_SHIFT_MAX - {2'h0, s_q.step[1:0]});
        scaled    = s_q.interval >> shift;
        dec_amt   = 10'h000;
        s_d.irq   = 1'b0;

        // Input synchronisers and edge history
        s_d.c1_sync[0] = comparator_one_in;
        s_d.c1_sync[1] = s_q.c1_sync[0];
        s_d.c2_sync[0] = comparator_two_in;
        s_d.c2_sync[1] = s_q.c2_sync[0];
        s_d.c1_prev    = c1_clean;
        s_d.c2_prev    = s_q.c2_sync[1];

        // Pulse start conditions
        if (s_q.state == pgn_pkg::PGN_IDLE) begin
            if (wr_pri && wr_data[pgn_pkg::BIT_OUT_EN]
                && !wr_data[pgn_pkg::BIT_MODE]) begin
                start = 1'b1;
            end else if (trig_ev && s_q.out_en) begin
                start = 1'b1;
            end
        end

        // Pulse timer and end of pulse
        unique case (s_q.state)
            pgn_pkg::PGN_IDLE: begin
                if (start) begin
                    s_d.state = pgn_pkg::PGN_PULSE;
                    s_d.timer = '0;
                    s_d.pulse = 1'b1;
                end
            end
            pgn_pkg::PGN_PULSE: begin
                if (tick) begin
                    s_d.timer = tnext;
                    if (tnext >= s_q.work) begin
                        done = 1'b1;
                    end
                end
            end
        endcase

        // Comparator two event: halt or shrink the width
        if (c2_ev) begin
            unique case (s_q.width_decrement_mode)
                2'h2: dec_amt = {7'h00, s_q.step} + 10'h001;
                2'h3: begin
                    if (scaled > 16'h01FE) begin
                        dec_amt = 10'h1FF;
                    end else begin
                        dec_amt = 10'(scaled + 16'h0001);
                    end
                end
                default: begin
                    s_d.out_en = 1'b0;
                    done       = s_q.state == pgn_pkg::PGN_PULSE;
                end
            endcase
        end
        if (done) begin
            s_d.state = pgn_pkg::PGN_IDLE;
            s_d.pulse = 1'b0;
            s_d.irq   = s_q.global_irq & s_q.pulse_irq_en;
            if (!sync_mode) begin
                s_d.out_en = 1'b0;
            end
        end

        // Comparator two interval in pulse clocks
        if (c2_ev) begin
            s_d.interval = '0;
        end else if (tick && sync_mode && s_q.interval != 16'hFFFF) begin
            s_d.interval = 16'(s_q.interval + 16'h0001);
        end

        // Working buffer approach toward the reload value
        if (s_q.reload_style && sync_mode) begin
            if (tick) begin
                if (s_q.appr_cnt >= appr_last) begin
                    s_d.appr_cnt = '0;
                    if (s_q.work < s_q.reload) begin
                        s_d.work = 9'(s_q.work + 9'h001);
                    end else if (s_q.work > s_q.reload) begin
                        s_d.work = 9'(s_q.work - 9'h001);
                    end
                end else begin
                    s_d.appr_cnt = 13'(s_q.appr_cnt + 13'h0001);
                end
            end
        end else begin
            s_d.appr_cnt = '0;
        end

        // Width decrement, saturating at zero
        if (dec_amt != 10'h000) begin
            if (dec_amt >= {1'b0, s_d.work}) begin
                s_d.work = '0;
            end else begin
                s_d.work = 9'({1'b0, s_d.work} - dec_amt);
            end
        end

        // Synchronous event counter with self-clearing clear bit
        if (s_q.cnt_clr) begin
            s_d.sync_count = '0;
            s_d.cnt_clr    = 1'b0;
        end else if (s_q.cnt_en && trig_ev) begin
            s_d.sync_count = 8'(s_q.sync_count + 8'h01);
        end

        // Register writes, applied last so a set wins
        if (wr_pri) begin
            s_d.out_en       = wr_data[pgn_pkg::BIT_OUT_EN];
            s_d.reload_style = wr_data[pgn_pkg::BIT_RELOAD_STYLE];
            s_d.mode         = wr_data[pgn_pkg::BIT_MODE];
            s_d.prescale     = wr_data[pgn_pkg::BIT_PRESCALE];
            s_d.cnt_en       = wr_data[pgn_pkg::BIT_CNT_EN];
            s_d.edge_sel     = wr_data[pgn_pkg::BIT_EDGE];
            if (wr_data[pgn_pkg::BIT_CNT_CLR]) begin
                s_d.cnt_clr = 1'b1;
            end
        end
        if (wr_sec) begin
            s_d.rate      = wr_data[pgn_pkg::POS_RATE +: 2];
            s_d.width_decrement_mode      = wr_data[pgn_pkg::POS_WIDTH_DECREMENT_MODE +: 2];
            s_d.step      = wr_data[pgn_pkg::POS_STEP +: 3];
            s_d.reload[8] = wr_data[pgn_pkg::BIT_RELOAD_MSB];
        end
        if (wr_low) begin
            s_d.reload[7:0] = wr_data;
        end

        // Direct style copies the reload on each reload write
        if ((wr_sec || wr_low)
            && !(s_d.reload_style && s_d.mode == pgn_pkg::MODE_SYNC)) begin
            s_d.work = s_d.reload;
        end

        // Interrupt enable, priority and debounce registers
        if (wr_en) begin
            unique case (addr)
                pgn_pkg::OFS_IRQ_MAIN:
                    s_d.global_irq = wr_data[pgn_pkg::BIT_GLOBAL_IRQ];
                pgn_pkg::OFS_IRQ_SECOND:
                    s_d.pulse_irq_en = wr_data[pgn_pkg::BIT_PULSE_IRQ];
                pgn_pkg::OFS_PRIO_LOW:
                    s_d.prio_low = wr_data[pgn_pkg::BIT_PULSE_IRQ];
                pgn_pkg::OFS_PRIO_HIGH:
                    s_d.prio_high = wr_data[pgn_pkg::BIT_PULSE_IRQ];
                pgn_pkg::OFS_DEBOUNCE:
                    s_d.debounce = wr_data[pgn_pkg::DBNC_W-1:0];
                default: ;
            endcase
        end

        // Read data, valid only in the cycle after the strobe
        s_d.rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                pgn_pkg::OFS_CTRL_PRI:
                    s_d.rd_data = {s_q.out_en, s_q.reload_style, 1'b0,
                                   s_q.mode, s_q.prescale, s_q.cnt_en,
                                   s_q.cnt_clr, s_q.edge_sel};
                pgn_pkg::OFS_CTRL_SEC:
                    s_d.rd_data = {s_q.rate, s_q.width_decrement_mode, s_q.step,
                                   s_q.reload[8]};
                pgn_pkg::OFS_RELOAD_LOW:
                    s_d.rd_data = s_q.reload[7:0];
                pgn_pkg::OFS_SYNC_COUNT:
                    s_d.rd_data = s_q.sync_count;
                pgn_pkg::OFS_TIMER_LOW:
                    s_d.rd_data = s_q.timer[7:0];
                pgn_pkg::OFS_TIMER_HIGH:
                    s_d.rd_data = {7'h00, s_q.timer[8]};
                pgn_pkg::OFS_IRQ_MAIN:
                    s_d.rd_data = {s_q.global_irq, 7'h00};
                pgn_pkg::OFS_IRQ_SECOND:
                    s_d.rd_data = {2'h0, s_q.pulse_irq_en, 5'h00};
                pgn_pkg::OFS_PRIO_LOW:
                    s_d.rd_data = {2'h0, s_q.prio_low, 5'h00};
                pgn_pkg::OFS_PRIO_HIGH:
                    s_d.rd_data = {2'h0, s_q.prio_high, 5'h00};
                pgn_pkg::OFS_DEBOUNCE:
                    s_d.rd_data = {3'h0, s_q.debounce};
                default:
                    s_d.rd_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // All fields reset to zero, idle state
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q       <= '0;
            s_q.state <= pgn_pkg::PGN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data       = s_q.rd_data;
    assign pulse_out     = s_q.pulse;
    assign irq_req       = s_q.irq;
    assign irq_prio_low  = s_q.prio_low;
    assign irq_prio_high = s_q.prio_high;

endmodule : pgn_top

/* tb/pgn_top_asserts.sv */
// Checker of register port and pulse output relations
`timescale 1ns/1ns
module pgn_top_asserts (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic       comparator_one_in,
    input wire logic       comparator_two_in,
    input wire logic [7:0] rd_data,
    input wire logic       pulse_out,
    input wire logic       irq_req,
    input wire logic       irq_prio_low,
    input wire logic       irq_prio_high
);
    // ------------------------------------------------------------
    // Shadow interrupt enables
    // ------------------------------------------------------------
    logic ga_q;
    logic pe_q;
    // Track enables from register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ga_q <= 1'b0;
            pe_q <= 1'b0;
        end else if (wr_en) begin
            if (addr == pgn_pkg::OFS_IRQ_MAIN) ga_q <= wr_data[7];
            if (addr == pgn_pkg::OFS_IRQ_SECOND) pe_q <= wr_data[5];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_start;
        wr_en && addr == pgn_pkg::OFS_CTRL_PRI && wr_data[7] && !wr_data[4]
            && !pulse_out;
    endsequence
    sequence s_prio_quiet;
        !(wr_en && (addr == pgn_pkg::OFS_PRIO_LOW
            || addr == pgn_pkg::OFS_PRIO_HIGH));
    endsequence
    chk_single_start: assert property (s_start |=> pulse_out)
        else $error("single pulse did not start");
    chk_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not idle");
    chk_rd_unmapped: assert property (rd_en && addr == 8'h00
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    chk_prio_low: assert property (wr_en && addr == pgn_pkg::OFS_PRIO_LOW
        |=> irq_prio_low == $past(wr_data[5])) else $error("prio low");
    chk_prio_high: assert property (wr_en && addr == pgn_pkg::OFS_PRIO_HIGH
        |=> irq_prio_high == $past(wr_data[5])) else $error("prio high");
    chk_prio_hold: assert property (s_prio_quiet
        |=> $stable(irq_prio_low) && $stable(irq_prio_high))
        else $error("prio moved");
    chk_irq_single: assert property (irq_req |=> !irq_req)
        else $error("interrupt longer than one cycle");
    chk_irq_gated: assert property (irq_req |-> $past(ga_q) && $past(pe_q))
        else $error("interrupt while disabled");
    chk_irq_quiet: assert property (irq_req |-> !pulse_out)
        else $error("interrupt during pulse");
endmodule : pgn_top_asserts
bind pgn_top pgn_top_asserts u_chk (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .comparator_one_in(comparator_one_in),
    .comparator_two_in(comparator_two_in),
    .rd_data(rd_data),
    .pulse_out(pulse_out),
    .irq_req(irq_req),
    .irq_prio_low(irq_prio_low),
    .irq_prio_high(irq_prio_high)
);

/* tb/pgn_cmp_model.sv */
// Model of the two comparator outputs feeding the generator
`timescale 1ns/1ns
module pgn_cmp_model (
    input  wire logic clk,
    output logic      comparator_one_in,
    output logic      comparator_two_in
);
    // Comparator outputs idle low
    initial begin
        comparator_one_in = 1'b0;
        comparator_two_in = 1'b0;
    end
    // One high phase then one low phase on comparator one
    task pulse1;
        @(posedge clk) comparator_one_in <= 1'b1;
        repeat (20) @(posedge clk);
        comparator_one_in <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : pulse1
    // One rising event on comparator two
    task ev2;
        @(posedge clk) comparator_two_in <= 1'b1;
        repeat (10) @(posedge clk);
        comparator_two_in <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : ev2
endmodule : pgn_cmp_model

/* tb/programmable_pulse_generator_tb.sv */
// Self-checking bench of the pulse generator
`timescale 1ns/1ns
module programmable_pulse_generator_tb;
    logic       clk, rst, wr_en, rd_en, comparator_one_in, comparator_two_in;
    logic [7:0] addr, wr_data, rd_data, rd_v;
    logic       pulse_out, irq_req, irq_prio_low, irq_prio_high;
    int         error_cnt, num_checks, cyc, irq_cnt, n, st, k, d;

    pgn_top DUT (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .comparator_one_in(comparator_one_in), .comparator_two_in(comparator_two_in),
        .rd_data(rd_data), .pulse_out(pulse_out), .irq_req(irq_req),
        .irq_prio_low(irq_prio_low), .irq_prio_high(irq_prio_high));
    pgn_cmp_model P (.clk(clk), .comparator_one_in(comparator_one_in), .comparator_two_in(comparator_two_in));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Cycle ceiling and interrupt pulse count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq_req === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cyc == 30000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rng(input int v, input int lo, input int hi);
        num_checks++;
        if (v < lo || v > hi) begin
            error_cnt++;
            $display("MISMATCH %0t count %0d not %0d..%0d", $time, v, lo, hi);
        end
    endtask : rng
    task wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge clk);
        addr <= a;
        wr_data <= dt;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rd_v = rd_data;
    endtask : rd
    // Start cycle and length of the next pulse
    task meas(output int s, output int len);
        len = 0;
        s = 0;
        repeat (100) begin
            #1;
            if (pulse_out === 1'b1) len++;
            else if (len > 0) break;
            else s++;
            @(posedge clk);
        end
    endtask : meas
    task sync_pulse;
        fork
            P.pulse1();
            meas(st, n);
        join
    endtask : sync_pulse
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(pgn_pkg::OFS_TIMER_LOW); chk(rd_v, pgn_pkg::RST_BYTE);
        rd(pgn_pkg::OFS_TIMER_HIGH); chk(rd_v, pgn_pkg::RST_BYTE);
        rd(8'h00); chk(rd_v, 8'h00);
        wr(pgn_pkg::OFS_PRIO_LOW, 8'h20);
        wr(pgn_pkg::OFS_PRIO_HIGH, 8'h20);
        #1 chk({6'h00, irq_prio_high, irq_prio_low}, 8'h03);
        wr(pgn_pkg::OFS_PRIO_LOW, 8'h00);
        #1 chk({6'h00, irq_prio_high, irq_prio_low}, 8'h02);
        wr(pgn_pkg::OFS_RELOAD_LOW, 8'h03);
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h01);
        rd(pgn_pkg::OFS_CTRL_SEC); chk(rd_v, 8'h01);
        rd(pgn_pkg::OFS_RELOAD_LOW); chk(rd_v, 8'h03);
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h00);
        wr(pgn_pkg::OFS_IRQ_MAIN, 8'h80);
        wr(pgn_pkg::OFS_IRQ_SECOND, 8'h20);
        // Single pulses of width 3 at both prescales, then no global
        for (int p = 0; p < 3; p++) begin
            d = (p == 1) ? 4 : 2;
            if (p == 2) wr(pgn_pkg::OFS_IRQ_MAIN, 8'h00);
            k = irq_cnt;
            wr(pgn_pkg::OFS_CTRL_PRI, (p == 1) ? 8'h88 : 8'h80);
            meas(st, n);
            rng(n, 2 * d + 1, 3 * d + 1);
            rd(pgn_pkg::OFS_CTRL_PRI); chk(rd_v & 8'h80, 8'h00);
            rng(irq_cnt - k, (p == 2) ? 0 : 1, (p == 2) ? 0 : 1);
        end
        // Synchronous mode, rising edge, counting on
        wr(pgn_pkg::OFS_CTRL_PRI, 8'h95);
        meas(st, n); rng(n, 0, 0);
        for (int i = 0; i < 2; i++) begin
            sync_pulse(); rng(n, 5, 7); rng(st, 2, 19);
        end
        rd(pgn_pkg::OFS_SYNC_COUNT); chk(rd_v, 8'h02);
        wr(pgn_pkg::OFS_CTRL_PRI, 8'h94);
        sync_pulse(); rng(n, 5, 7); rng(st, 22, 40);
        wr(pgn_pkg::OFS_CTRL_PRI, 8'h91);
        sync_pulse();
        rd(pgn_pkg::OFS_SYNC_COUNT); chk(rd_v, 8'h03);
        wr(pgn_pkg::OFS_CTRL_PRI, 8'h93);
        rd(pgn_pkg::OFS_SYNC_COUNT); chk(rd_v, 8'h00);
        rd(pgn_pkg::OFS_CTRL_PRI); chk(rd_v & 8'h02, 8'h00);
        // Constant step of 3 from width 10
        wr(pgn_pkg::OFS_RELOAD_LOW, 8'h0A);
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h24);
        P.ev2();
        sync_pulse(); rng(n, 13, 15);
        // Step of 8 from width 3 saturates at zero
        wr(pgn_pkg::OFS_RELOAD_LOW, 8'h03);
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h2E);
        P.ev2();
        sync_pulse(); rng(n, 1, 3);
        // Variable step, shift 3: about 11 ticks between events takes 2
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h36);
        P.ev2();
        wr(pgn_pkg::OFS_RELOAD_LOW, 8'h0A);
        P.ev2();
        // Debounce of 4 ticks delays the trigger by about 8 clocks
        wr(pgn_pkg::OFS_DEBOUNCE, 8'h04);
        sync_pulse(); rng(n, 15, 17); rng(st, 10, 14);
        // Approach from 8 toward 10, one step per 512 ticks
        wr(pgn_pkg::OFS_CTRL_PRI, 8'hD1);
        repeat (1100) @(posedge clk);
        sync_pulse(); rng(n, 17, 19);
        // Halt on comparator two event
        wr(pgn_pkg::OFS_CTRL_SEC, 8'h00);
        P.ev2();
        rd(pgn_pkg::OFS_CTRL_PRI); chk(rd_v & 8'h80, 8'h00);
        sync_pulse(); rng(n, 0, 0);
        stop_test();
    end
endmodule : programmable_pulse_generator_tb
